/* rtl/pts_timing_top.sv */
// pulse latency/window timing and auto-sleep control with its registers
// assumes a classic wishbone master on mclk and event pulses on mclk

// Summary of operation
// (R1) ignore pulses during latency after first pulse
// (R2) software always programs a latency value
// (R3) latency equals count times rate step
// (R4) latency step from rate, mode, lowpass table
// (R5) second pulse start only inside window
// (R6) second pulse must be shorter than limit
// (R7) second pulse may end after window
// (R8) window equals count times rate step
// (R9) window step uses the same table
// (R10) sleep after inactivity reaches sleep count
// (R11) count unit 320 ms, 640 ms slowest
// (R12) four motion events restart count and wake
// (R13) transition and sample events do neither
// (R14) wake needs interrupt enable and wake select
// (R15) functions keep running at sleep rate
// (R16) auto-sleep off never enters sleep
// (R17) each sleep transition raises an interrupt
// (R18) sleep rate field picks sleep frequency
// (R19) sleep rate overrides rate for everything
// (R20) time limit bounds above-threshold duration
// (R21) wake restores active rate, count restarts
module pts_timing_top #(
  parameter int BASE_CYCLES = pts_pkg::BASE_CYCLES
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic                        ce,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [pts_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  input  wire pts_pkg::pts_events_type     eventsIn,
  input  wire pts_pkg::pts_pulse_in_type   pulseIn,
  output pts_pkg::pts_pulse_out_type       pulseOut,
  output logic      [2:0]                  effectiveRate,
  output logic      [1:0]                  effectiveMode,
  output logic                             sampleTick,
  output logic                             sleeping,
  output logic                             sleepTransitionIrq
);
  import pts_pkg::*;

  // ****************
  // state
  // ****************
  typedef struct packed {
    pts_config_type cfg;
    pts_power_type  power;
    logic [16:0]    idle;
    logic           ack;
    logic [7:0]     rdat;
    logic [2:0]     effRate;
    logic [1:0]     effMode;
    logic           sleeping;
    logic           irq;
  } pts_top_reg_type;

  localparam pts_top_reg_type TOP_RESET = '{
    cfg: '{latency: LATENCY_RST, window: WINDOW_RST,
           sleepCount: SLEEP_CNT_RST, default: '0},
    power: PTS_STANDBY,
    default: '0};

  pts_top_reg_type q;
  pts_top_reg_type d;

  logic        baseTick;
  logic        running;
  logic [3:0]  rateShift;
  logic [3:0]  eventVec;
  logic        activity;
  logic        wakeHit;
  logic [16:0] sleepTarget;
  logic [15:0] latencyTarget;
  logic [15:0] windowTarget;
  logic [5:0]  regIdx;
  logic        reqNew;
  logic        wrNow;
  logic [7:0]  wrByte;

  // ****************
  // helpers
  // ****************
  // (R4) step exponent from table
  function automatic logic [3:0] stepExp(
    input logic [2:0] rate,
    input logic [1:0] mode,
    input logic       lowpass
  );
    logic [31:0] row;
    row     = STEP_TABLE[{lowpass, mode}];
    stepExp = row[{rate, 2'b00} +: 4];
  endfunction

  // (R3) count times step, 255 steps max
  function automatic logic [15:0] stepSpan(
    input logic [7:0] count,
    input logic [3:0] shift
  );
    stepSpan = {8'h00, count} << shift;
  endfunction

  // (R18) sleep codes map onto the four slowest rates
  function automatic logic [2:0] sleepRateCode(input logic [1:0] sel);
    sleepRateCode = {1'b1, sel};
  endfunction

  // ****************
  // timing helpers
  // ****************
  pts_rate_ticker #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_ticker (
    .mclk       (mclk),
    .rst        (rst),
    .ce         (ce),
    .run        (running),
    .rateShift  (rateShift),
    .baseTick   (baseTick),
    .sampleTick (sampleTick)
  );

  pts_pulse_timer u_pulse (
    .mclk          (mclk),
    .rst           (rst),
    .ce            (ce),
    .run           (running),
    .baseTick      (baseTick),
    .doubleEnable  (q.cfg.doublePulse),
    .latencyTarget (latencyTarget),
    .windowTarget  (windowTarget),
    .pulseIn       (pulseIn),
    .pulseOut      (pulseOut)
  );

  always_comb begin
    running   = (q.power != PTS_STANDBY);
    rateShift = SAMPLE_SHIFT[{q.effRate, 2'b00} +: 4];
    // (R15) timers paced by effective rate
    // (R3) latency span
    latencyTarget = stepSpan(q.cfg.latency,
                             stepExp(q.effRate, q.effMode, q.cfg.lowpass));
    // (R8) window span, (R9) same table
    windowTarget  = stepSpan(q.cfg.window,
                             stepExp(q.effRate, q.effMode, q.cfg.lowpass));
  end

  // ****************
  // activity and wake sources
  // ****************
  always_comb begin
    eventVec                = '0;
    eventVec[EVT_TRANSIENT] = eventsIn.transient;
    eventVec[EVT_ORIENT]    = eventsIn.orientation;
    eventVec[EVT_TAP]       = pulseOut.singleTap | pulseOut.doubleTap;
    eventVec[EVT_MOTION]    = eventsIn.motion;
    // (R12) four sources restart the count
    // (R13) transition and sample-ready not included
    activity = |(eventVec & q.cfg.intEnable);
    // (R14) enabled and selected to wake
    wakeHit  = |(eventVec & q.cfg.intEnable & q.cfg.wakeSelect);
    // (R11) unit doubles at slowest active rate
    if (q.cfg.activeRate == SLOW_RATE) begin
      sleepTarget = 17'(q.cfg.sleepCount) * 17'(SLEEP_UNIT_SLOW_TICKS);
    end else begin
      sleepTarget = 17'(q.cfg.sleepCount) * 17'(SLEEP_UNIT_TICKS);
    end
  end

  // ****************
  // bus decode
  // ****************
  always_comb begin
    regIdx = wb_adr_i[ADR_W-1:2];
    reqNew = wb_cyc_i & wb_stb_i & ~q.ack;
    // write lands on the edge that samples ack
    wrNow  = wb_cyc_i & wb_stb_i & wb_we_i & q.ack & wb_sel_i[0];
    wrByte = wb_dat_i[7:0];
  end

  // ****************
  // next state
  // ****************
  always_comb begin
    d     = q;
    d.irq = 1'b0;
    d.ack = reqNew;

    if (reqNew) begin
      case (regIdx)
        IDX_LATENCY:   d.rdat = q.cfg.latency;
        IDX_WINDOW:    d.rdat = q.cfg.window;
        IDX_SLEEP_CNT: d.rdat = q.cfg.sleepCount;
        IDX_SYS_ONE: begin
          d.rdat = '0;
          d.rdat[SYS1_ACTIVE] = q.cfg.active;
          d.rdat[SYS1_RATE_LSB +: 3] = q.cfg.activeRate;
          d.rdat[SYS1_SRATE_LSB +: 2] = q.cfg.sleepRate;
        end
        IDX_SYS_TWO: begin
          d.rdat = '0;
          d.rdat[SYS2_MODS_LSB +: 2] = q.cfg.mods;
          d.rdat[SYS2_SLEEP_EN] = q.cfg.autoSleep;
          d.rdat[SYS2_SMODS_LSB +: 2] = q.cfg.smods;
        end
        IDX_WAKE_SEL:  d.rdat = {4'h0, q.cfg.wakeSelect};
        IDX_INT_EN: begin
          d.rdat = {4'h0, q.cfg.intEnable};
          d.rdat[INT_SLEEP_EN] = q.cfg.sleepIrqEnable;
        end
        IDX_PULSE_CFG: begin
          d.rdat = '0;
          d.rdat[PCFG_LOWPASS] = q.cfg.lowpass;
          d.rdat[PCFG_DOUBLE] = q.cfg.doublePulse;
        end
        IDX_STATUS: begin
          d.rdat = {3'h0, q.effRate == q.cfg.activeRate,
                    pulseOut.windowActive, pulseOut.latencyActive,
                    q.power == PTS_SLEEP, q.power == PTS_WAKE};
        end
        default: d.rdat = '0;
      endcase
    end

    if (wrNow) begin
      case (regIdx)
        IDX_LATENCY:   d.cfg.latency    = wrByte;
        IDX_WINDOW:    d.cfg.window     = wrByte;
        IDX_SLEEP_CNT: d.cfg.sleepCount = wrByte;
        IDX_SYS_ONE: begin
          d.cfg.active     = wrByte[SYS1_ACTIVE];
          d.cfg.activeRate = wrByte[SYS1_RATE_LSB +: 3];
          d.cfg.sleepRate  = wrByte[SYS1_SRATE_LSB +: 2];
        end
        IDX_SYS_TWO: begin
          d.cfg.mods      = wrByte[SYS2_MODS_LSB +: 2];
          d.cfg.autoSleep = wrByte[SYS2_SLEEP_EN];
          d.cfg.smods     = wrByte[SYS2_SMODS_LSB +: 2];
        end
        IDX_WAKE_SEL:  d.cfg.wakeSelect = wrByte[3:0];
        IDX_INT_EN: begin
          d.cfg.intEnable      = wrByte[3:0];
          d.cfg.sleepIrqEnable = wrByte[INT_SLEEP_EN];
        end
        IDX_PULSE_CFG: begin
          d.cfg.lowpass     = wrByte[PCFG_LOWPASS];
          d.cfg.doublePulse = wrByte[PCFG_DOUBLE];
        end
        default: d.cfg = q.cfg;
      endcase
    end

    // power sequencing uses the settings held before this edge
    case (q.power)
      PTS_STANDBY: begin
        d.idle = '0;
        if (q.cfg.active) begin
          d.power = PTS_WAKE;
        end
      end
      PTS_WAKE: begin
        if (!q.cfg.active) begin
          d.power = PTS_STANDBY;
        end else if (activity) begin
          // (R12) event restarts inactivity
          d.idle = '0;
        end else if (q.cfg.autoSleep && sampleTick && q.idle >= sleepTarget) begin
          // (R10) enough inactivity, go to sleep
          d.power = PTS_SLEEP;
          d.idle  = '0;
          // (R17) active to sleep interrupt
          d.irq   = q.cfg.sleepIrqEnable;
        end else if (baseTick && q.idle != '1) begin
          d.idle = q.idle + 17'h1;
        end
      end
      PTS_SLEEP: begin
        d.idle = '0;
        if (!q.cfg.active) begin
          d.power = PTS_STANDBY;
        end else if (!q.cfg.autoSleep || wakeHit) begin
          // (R16) cleared enable leaves sleep
          // (R21) wake restores active rate
          d.power = PTS_WAKE;
          // (R17) sleep to active interrupt
          d.irq   = q.cfg.sleepIrqEnable;
        end
      end
      default: begin
        d.power = PTS_STANDBY;
      end
    endcase

    // (R19) sleep rate overrides for all
    if (d.power == PTS_SLEEP) begin
      // (R18) sleep frequency select
      d.effRate = sleepRateCode(q.cfg.sleepRate);
      d.effMode = q.cfg.smods;
    end else begin
      d.effRate = q.cfg.activeRate;
      d.effMode = q.cfg.mods;
    end
    d.sleeping = (d.power == PTS_SLEEP);
  end

  // ****************
  // registers
  // ****************
  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= TOP_RESET;
    end else if (ce) begin
      q <= d;
    end
  end

  // upper data lanes are constant zero
  assign wb_dat_o           = {24'h000000, q.rdat};
  assign wb_ack_o           = q.ack;
  assign effectiveRate      = q.effRate;
  assign effectiveMode      = q.effMode;
  assign sleeping           = q.sleeping;
  assign sleepTransitionIrq = q.irq;

endmodule

/* inc/pts_pkg.sv */
// constants, tables and carriers for the pulse timers and auto-sleep
// assumes mclk at 50 MHz and 8-bit registers on a 32-bit wishbone bus
package pts_pkg;

  // ****************
  // timing
  // ****************
  localparam int CLK_FREQ_HZ           = 50_000_000;
  localparam int BASE_STEP_US          = 1250;
  localparam int BASE_CYCLES           = BASE_STEP_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int SLEEP_UNIT_US         = 320_000;
  localparam int SLEEP_UNIT_SLOW_US    = 640_000;
  localparam int SLEEP_UNIT_TICKS      = SLEEP_UNIT_US / BASE_STEP_US;
  localparam int SLEEP_UNIT_SLOW_TICKS = SLEEP_UNIT_SLOW_US / BASE_STEP_US;

  // ****************
  // register map (index, byte address is four times it)
  // ****************
  localparam int         ADR_W          = 8;
  localparam logic [5:0] IDX_LATENCY    = 6'h27;
  localparam logic [5:0] IDX_WINDOW     = 6'h28;
  localparam logic [5:0] IDX_SLEEP_CNT  = 6'h29;
  localparam logic [5:0] IDX_SYS_ONE    = 6'h2a;
  localparam logic [5:0] IDX_SYS_TWO    = 6'h2b;
  localparam logic [5:0] IDX_WAKE_SEL   = 6'h2c;
  localparam logic [5:0] IDX_INT_EN     = 6'h2d;
  localparam logic [5:0] IDX_PULSE_CFG  = 6'h2e;
  localparam logic [5:0] IDX_STATUS     = 6'h2f;
  localparam logic [7:0] LATENCY_RST    = 8'h00;
  localparam logic [7:0] WINDOW_RST     = 8'h00;
  localparam logic [7:0] SLEEP_CNT_RST  = 8'h00;

  // field positions
  localparam int SYS1_ACTIVE    = 0;
  localparam int SYS1_RATE_LSB  = 1;
  localparam int SYS1_SRATE_LSB = 4;
  localparam int SYS2_MODS_LSB  = 0;
  localparam int SYS2_SLEEP_EN  = 2;
  localparam int SYS2_SMODS_LSB = 3;
  localparam int INT_SLEEP_EN   = 4;
  localparam int PCFG_LOWPASS   = 0;
  localparam int PCFG_DOUBLE    = 1;
  localparam int EVT_TRANSIENT  = 0;
  localparam int EVT_ORIENT     = 1;
  localparam int EVT_TAP        = 2;
  localparam int EVT_MOTION     = 3;

  // ****************
  // rate tables, one nibble per rate code, code 0 lowest
  // ****************
  localparam logic [2:0]  SLOW_RATE    = 3'h7;
  localparam logic [31:0] SAMPLE_SHIFT = 32'h9764_3210;
  // log2 of step in base ticks, indexed {lowpass, mode}
  localparam logic [7:0][31:0] STEP_TABLE = {
    32'h8875_4321, 32'h2222_2221, 32'h7775_4321, 32'h5555_4321,
    32'h6664_3210, 32'h0000_0000, 32'h5553_2100, 32'h3333_2100};

  // ****************
  // types
  // ****************
  typedef enum logic [1:0] {PTS_STANDBY, PTS_WAKE, PTS_SLEEP} pts_power_type;
  typedef enum logic [1:0] {TAP_IDLE, TAP_LATENCY, TAP_WINDOW, TAP_SECOND} pts_tap_type;

  typedef struct packed {
    logic start;
    logic accepted;
    logic rejected;
  } pts_pulse_in_type;

  typedef struct packed {
    logic singleTap;
    logic doubleTap;
    logic latencyActive;
    logic windowActive;
  } pts_pulse_out_type;

  typedef struct packed {
    logic transient;
    logic orientation;
    logic motion;
  } pts_events_type;

  typedef struct packed {
    logic [7:0] latency;
    logic [7:0] window;
    logic [7:0] sleepCount;
    logic       active;
    logic [2:0] activeRate;
    logic [1:0] sleepRate;
    logic       autoSleep;
    logic [1:0] mods;
    logic [1:0] smods;
    logic [3:0] wakeSelect;
    logic [3:0] intEnable;
    logic       sleepIrqEnable;
    logic       lowpass;
    logic       doublePulse;
  } pts_config_type;

endpackage

/* rtl/pts_rate_ticker.sv */
// base tick (fastest sample period) and sample tick at the current rate
// assumes run follows the power state and rateShift is registered
module pts_rate_ticker #(
  parameter int BASE_CYCLES = pts_pkg::BASE_CYCLES
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [3:0] rateShift,
  output logic            baseTick,
  output logic            sampleTick
);
  import pts_pkg::*;

  localparam int CW = $clog2(BASE_CYCLES);

  typedef struct packed {
    logic [CW-1:0] div;
    logic [8:0]    sub;
    logic          baseTick;
    logic          sampleTick;
  } pts_ticker_reg_type;

  pts_ticker_reg_type q;
  pts_ticker_reg_type d;
  logic [9:0]         subSpan;

  always_comb begin
    subSpan      = (10'h1 << rateShift) - 10'h1;
    d            = q;
    d.baseTick   = 1'b0;
    d.sampleTick = 1'b0;
    if (!run) begin
      d.div = '0;
      d.sub = '0;
    end else if (q.div == CW'(BASE_CYCLES - 1)) begin
      d.div      = '0;
      d.baseTick = 1'b1;
      // >= so a shorter period after a rate change cannot overrun
      if (q.sub >= subSpan[8:0]) begin
        d.sub        = '0;
        d.sampleTick = 1'b1;
      end else begin
        d.sub = q.sub + 9'h1;
      end
    end else begin
      d.div = q.div + CW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign baseTick   = q.baseTick;
  assign sampleTick = q.sampleTick;

endmodule

/* rtl/pts_pulse_timer.sv */
// latency and second-pulse window sequencer of the tap detector
// assumes the pulse qualifier outside judges threshold and time limit
module pts_pulse_timer (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic                      run,
  input  wire logic                      baseTick,
  input  wire logic                      doubleEnable,
  input  wire logic [15:0]               latencyTarget,
  input  wire logic [15:0]               windowTarget,
  input  wire pts_pkg::pts_pulse_in_type pulseIn,
  output pts_pkg::pts_pulse_out_type     pulseOut
);
  import pts_pkg::*;

  typedef struct packed {
    pts_tap_type       phase;
    logic [15:0]       elapsed;
    pts_pulse_out_type out;
  } pts_tap_reg_type;

  pts_tap_reg_type q;
  pts_tap_reg_type d;

  always_comb begin
    d               = q;
    d.out.singleTap = 1'b0;
    d.out.doubleTap = 1'b0;
    if (baseTick) begin
      d.elapsed = q.elapsed + 16'h1;
    end
    case (q.phase)
      TAP_IDLE: begin
        if (pulseIn.accepted) begin
          d.out.singleTap = 1'b1;
          d.elapsed       = '0;
          d.phase         = TAP_LATENCY;
        end
      end
      // (R1) pulses ignored here
      TAP_LATENCY: begin
        if (q.elapsed >= latencyTarget) begin
          d.elapsed = '0;
          d.phase   = doubleEnable ? TAP_WINDOW : TAP_IDLE;
        end
      end
      // (R5) only a start inside window
      TAP_WINDOW: begin
        if (q.elapsed >= windowTarget) begin
          d.phase = TAP_IDLE;
        end else if (pulseIn.start) begin
          d.phase = TAP_SECOND;
        end
      end
      // (R7) end may fall after window
      TAP_SECOND: begin
        // (R6) (R20) width judged by time limit
        if (pulseIn.accepted) begin
          d.out.doubleTap = 1'b1;
          d.phase         = TAP_IDLE;
        end else if (pulseIn.rejected) begin
          d.phase = TAP_IDLE;
        end
      end
      default: begin
        d.phase = TAP_IDLE;
      end
    endcase
    if (!run) begin
      d.phase   = TAP_IDLE;
      d.elapsed = '0;
    end
    d.out.latencyActive = (d.phase == TAP_LATENCY);
    d.out.windowActive  = (d.phase == TAP_WINDOW);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign pulseOut = q.out;

endmodule

/* tb/pts_timing_checker.sv */
// port assertions for the pulse timers and auto-sleep control
// assumes a bind into pts_timing_top, rst synchronous active high
module pts_timing_checker #(
  parameter int BASE_CYCLES = 10
) (
  input wire logic                       mclk,
  input wire logic                       rst,
  input wire logic                       ce,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_ack_o,
  input wire pts_pkg::pts_pulse_in_type  pulseIn,
  input wire pts_pkg::pts_pulse_out_type pulseOut,
  input wire logic [2:0]                 effectiveRate,
  input wire logic                       sampleTick,
  input wire logic                       sleeping,
  input wire logic                       sleepTransitionIrq
);
  import pts_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // ****************
  // register bus
  // ****************
  AST_ACK_ONE:
    assert property (ce && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  AST_ACK_DROP:
    assert property (ce && wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  // ****************
  // tap timers
  // ****************
  // rose, since a frozen clock enable may hold a pulse
  AST_TAP_CAUSE:
    assert property ($rose(pulseOut.singleTap || pulseOut.doubleTap)
                     |-> $past(pulseIn.accepted))
    else $error("tap without accepted pulse");
  AST_LAT_IGNORE:
    assert property (pulseOut.latencyActive && pulseIn.accepted
                     |=> !pulseOut.singleTap && !pulseOut.doubleTap)
    else $error("pulse taken during latency");
  AST_WIN_AFTER_LAT:
    assert property ($rose(pulseOut.windowActive)
                     |-> $past(pulseOut.latencyActive || pulseIn.accepted))
    else $error("window opened without latency");
  AST_WIN_CLOSE:
    assert property (ce && pulseOut.windowActive && pulseIn.start |=> !pulseOut.windowActive)
    else $error("window stayed open after start");
  // ****************
  // auto-sleep
  // ****************
  AST_SLEEP_AT_TICK:
    assert property ($rose(sleeping) |-> $past(sampleTick))
    else $error("sleep entered off a sample tick");
  AST_SLEEP_RATE:
    assert property (sleeping |-> effectiveRate[2])
    else $error("sleep rate not in force");
  AST_IRQ_ON_CHANGE:
    assert property ($rose(sleepTransitionIrq) |-> $changed(sleeping))
    else $error("irq without transition");
  AST_IRQ_ONE:
    assert property (ce && sleepTransitionIrq |=> !sleepTransitionIrq)
    else $error("irq longer than one cycle");
  cover property ($rose(sleeping));
  cover property ($fell(sleeping));
  cover property (pulseOut.doubleTap);
endmodule

/* tb/pts_timing_top_test.sv */
// self-checking bench for the pulse timers and auto-sleep control
// assumes a one-cycle wishbone answer and base step shortened to 10 clocks
module pts_timing_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pts_pkg::*;
  localparam int BC = 10;
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic              ce = 1'b1;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0;
  logic [7:0]        wb_adr_i = 8'h00;
  logic [3:0]        wb_sel_i = 4'h0;
  logic [31:0]       wb_dat_i = 32'h0;
  logic [31:0]       wb_dat_o;
  logic              wb_ack_o;
  pts_events_type    eventsIn = '0;
  pts_pulse_in_type  pulseIn = '0;
  pts_pulse_out_type pulseOut;
  logic [2:0]        effectiveRate;
  logic [1:0]        effectiveMode;
  logic              sampleTick;
  logic              sleeping;
  logic              sleepTransitionIrq;
  int                mismatches = 0;
  int                checkCount = 0;
  int                singles = 0;
  int                doubles = 0;
  int                irqs = 0;
  // {system one, system two, pulse config, base ticks per step}
  logic [31:0]       cases [6] = '{32'h01000201, 32'h01000302, 32'h03030202,
                                   32'h0b000208, 32'h0b020304, 32'h0b010220};
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    singles += int'(pulseOut.singleTap === 1'b1);
    doubles += int'(pulseOut.doubleTap === 1'b1);
    irqs += int'(sleepTransitionIrq === 1'b1);
  end
  pts_timing_top #(.BASE_CYCLES(BC)) DUT (
    .mclk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .eventsIn, .pulseIn, .pulseOut, .effectiveRate,
    .effectiveMode, .sampleTick, .sleeping, .sleepTransitionIrq);
  task automatic endSim();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic step(inout int n, input int lim);
    @(posedge mclk);
    n++;
    if (n > lim) begin
      mismatches++;
      $display("unexpected at %0t: waited %h limit %h", $time, n, lim);
      endSim();
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d,
                     input logic [3:0] s, output logic [7:0] r);
    int n;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {i, 2'b00};
    wb_sel_i <= s;
    wb_dat_i <= {24'h0, d};
    n = 0;
    do step(n, 20); while (wb_ack_o !== 1'b1);
    r = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, i, d, 4'h1, r);
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, i, 8'h00, 4'hf, r);
    chk(r, e);
  endtask
  // {events, pulse} high for one cycle
  task automatic drive(input logic [5:0] v);
    @(posedge mclk);
    eventsIn <= v[5:3];
    pulseIn <= v[2:0];
    @(posedge mclk);
    eventsIn <= 3'h0;
    pulseIn <= 3'h0;
  endtask
  // one step of slack: the free base tick is not aligned to the pulse
  task automatic timed(input int t, input int s, input logic win);
    int n;
    n = 0;
    while ((win ? pulseOut.windowActive : pulseOut.latencyActive) !== 1'b1) step(n, 9000);
    n = 0;
    while ((win ? pulseOut.windowActive : pulseOut.latencyActive) === 1'b1) step(n, 9000);
    chk(n >= (t - s) * BC && n <= (t + s) * BC + 3, 1'b1);
  endtask
  task automatic toWin();
    int n;
    drive(6'h02);
    n = 0;
    while (pulseOut.windowActive !== 1'b1) step(n, 500);
  endtask
  initial begin
    logic [7:0] r;
    int n;
    int b;
    int q;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    // ****************
    // registers
    // ****************
    rd(IDX_LATENCY, 8'h00);
    rd(IDX_WINDOW, 8'h00);
    rd(IDX_SLEEP_CNT, 8'h00);
    wr(IDX_LATENCY, 8'ha5);
    bus(1'b1, IDX_WINDOW, 8'h5a, 4'h0, r);
    wr(6'h10, 8'hff);
    wr(IDX_SLEEP_CNT, 8'hff);
    rd(IDX_LATENCY, 8'ha5);
    rd(IDX_WINDOW, 8'h00);
    rd(6'h10, 8'h00);
    rd(IDX_SLEEP_CNT, 8'hff);
    $display("test registers done");
    // ****************
    // latency and window
    // ****************
    wr(IDX_LATENCY, 8'h04);
    wr(IDX_SYS_ONE, 8'h01);
    b = singles;
    drive(6'h02);
    drive(6'h02);
    timed(4, 1, 1'b0);
    chk(singles, b + 1);
    wr(IDX_WINDOW, 8'h03);
    foreach (cases[k]) begin
      wr(IDX_SYS_ONE, 8'h00);
      wr(IDX_SYS_TWO, cases[k][23:16]);
      wr(IDX_PULSE_CFG, cases[k][15:8]);
      wr(IDX_SYS_ONE, cases[k][31:24]);
      b = doubles;
      drive(6'h02);
      timed(4 * cases[k][7:0], cases[k][7:0], 1'b0);
      timed(3 * cases[k][7:0], cases[k][7:0], 1'b1);
      chk(doubles, b);
    end
    $display("test timer steps done");
    // ****************
    // double tap
    // ****************
    wr(IDX_SYS_ONE, 8'h00);
    wr(IDX_SYS_TWO, 8'h00);
    wr(IDX_PULSE_CFG, 8'h02);
    wr(IDX_LATENCY, 8'h02);
    wr(IDX_SYS_ONE, 8'h01);
    b = doubles;
    toWin();
    drive(6'h04);
    repeat (60) @(posedge mclk);
    drive(6'h02);
    repeat (3) @(posedge mclk);
    chk(doubles, b + 1);
    toWin();
    drive(6'h04);
    drive(6'h01);
    repeat (3) @(posedge mclk);
    chk(doubles, b + 1);
    toWin();
    n = 0;
    while (pulseOut.windowActive === 1'b1) step(n, 500);
    drive(6'h04);
    drive(6'h02);
    repeat (3) @(posedge mclk);
    chk(doubles, b + 1);
    $display("test double tap done");
    // ****************
    // auto-sleep
    // ****************
    wr(IDX_SYS_ONE, 8'h00);
    wr(IDX_PULSE_CFG, 8'h00);
    wr(IDX_SLEEP_CNT, 8'h01);
    wr(IDX_SYS_TWO, 8'h0c);
    wr(IDX_WAKE_SEL, 8'h01);
    wr(IDX_INT_EN, 8'h13);
    wr(IDX_SYS_ONE, 8'h11);
    q = irqs;
    repeat (1500) @(posedge mclk);
    drive(6'h10);
    n = 0;
    while (sleeping !== 1'b1) step(n, 4000);
    chk(n >= 255 * BC && n <= 258 * BC, 1'b1);
    repeat (2) @(posedge mclk);
    chk(irqs, q + 1);
    chk(effectiveRate, 3'h5);
    chk(effectiveMode, 2'h1);
    b = singles;
    drive(6'h10);
    drive(6'h08);
    drive(6'h02);
    repeat (3) @(posedge mclk);
    chk(sleeping, 1'b1);
    chk(singles, b + 1);
    drive(6'h20);
    @(posedge mclk);
    chk(sleeping, 1'b0);
    chk(effectiveRate, 3'h0);
    chk(effectiveMode, 2'h0);
    n = 0;
    while (sleeping !== 1'b1) step(n, 4000);
    chk(n >= 254 * BC && n <= 258 * BC, 1'b1);
    wr(IDX_SYS_TWO, 8'h00);
    repeat (5) @(posedge mclk);
    b = 0;
    repeat (3000) begin
      @(posedge mclk);
      b += int'(sleeping !== 1'b0);
    end
    chk(b, 0);
    chk(irqs, q + 4);
    $display("test auto-sleep done");
    // low clock enable must hold a running latency
    drive(6'h02);
    ce <= 1'b0;
    repeat (100) @(posedge mclk);
    chk(pulseOut.latencyActive, 1'b1);
    ce <= 1'b1;
    $display("test clock enable done");
    endSim();
  end
endmodule
bind pts_timing_top pts_timing_checker #(.BASE_CYCLES(BASE_CYCLES)) chk (
  .mclk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .pulseIn, .pulseOut,
  .effectiveRate, .sampleTick, .sleeping, .sleepTransitionIrq);
